// ### common/fsq_regs_defs.svh
// Offsets, field positions, reset values and timing figures of the sequencer register bank
`ifndef FSQ_REGS_DEFS_SVH
`define FSQ_REGS_DEFS_SVH

`define FSQ_ADDR_W          32
`define FSQ_OFS_CLK_NOTIFY  32'hFFA100E4
`define FSQ_OFS_ECC_MON     32'hFFA10100
`define FSQ_OFS_ECC_TMD     32'hFFA10104
`define FSQ_OFS_DUMMY       32'hFFA10108
`define FSQ_OFS_FW_SEL      32'hFFC59008
`define FSQ_OFS_MODE_ENTRY  32'hFFA10200
`define FSQ_OFS_STATUS      32'hFFA10204
`define FSQ_OFS_WORK        32'hFFA10208

`define FSQ_KEY_FREQ        8'h1E
`define FSQ_KEY_ECC         8'hA6
`define FSQ_MODE_CODE       16'h0001
`define FSQ_MODE_DATA       16'h0080
`define FSQ_MODE_READ       16'h0000

`define FSQ_FREQ_MAX        8'h64
`define FSQ_TMD_RST         16'h0030
`define FSQ_DUMMY_RST       10'h3FF
`define FSQ_MON_RST         16'hFFFF
`define FSQ_MON_RSV         6'h3F

`define FSQ_BIT_CVE         5
`define FSQ_BIT_DVE         4
`define FSQ_BIT_EDIS        0
`define FSQ_BIT_RDY         7

`define FSQ_FW_LO           32'h00017000
`define FSQ_FW_HI           32'h00017FFF
`define FSQ_FW_ALT_LO       32'h01037000
`define FSQ_FW_ALT_HI       32'h01037FFF

// Base work of one command, in microseconds; cycles derived from notified MHz
`define FSQ_WORK_US         8'h02
`endif

// ### common/fsq_regs_pkg.sv
// Types of the sequencer register bank
package fsq_regs_pkg;
    typedef enum logic [1:0] {FSQ_READ, FSQ_CODE, FSQ_DATA} fsq_mode_e;
    typedef enum logic [1:0] {FSQ_IDLE, FSQ_RUN} fsq_state_e;
    typedef struct packed {
        logic       code_verify_ecc_area_en;
        logic       data_verify_ecc_area_en;
        logic       encoder_disable;
    } fsq_tmd_s;
    typedef struct packed {
        logic       parity;
        logic [8:0] ecc;
    } fsq_check_s;
    typedef logic [15:0] fsq_word_t;
endpackage : fsq_regs_pkg

// ### rtl/fsq_regs.sv
// Sequencer clock notify, ECC test and firmware map register bank
`timescale 1ns/1ns
`include "fsq_regs_defs.svh"
module fsq_regs
    import fsq_regs_pkg::*;
(
    input  wire logic                   CLK,
    input  wire logic                   ARST_N,
    input  wire logic [31:0]            ADDR,
    input  wire logic [15:0]            WDATA,
    input  wire logic                   WR,
    input  wire logic                   RD,
    output logic      [15:0]            RDATA,
    input  wire logic                   SERIAL_BOOT,
    input  wire logic                   CMD_START,
    input  wire logic [8:0]             CODE_ECC_IN,
    input  wire logic                   CODE_PARITY_IN,
    input  wire logic [6:0]             DATA_ECC_IN,
    input  wire logic [31:0]            FETCH_ADDR,
    output logic                        READY,
    output logic      [9:0]             WRITE_CHECK,
    output logic                        VERIFY_ECC_AREA,
    output logic                        FW_HIT,
    output logic                        FW_ALT_HIT
);

    logic       [7:0]   notified_freq_mhz;
    fsq_tmd_s           tmd;
    fsq_check_s         dummy;
    logic               firmware_map_sel;
    logic       [1:0]   boot_wait;
    fsq_mode_e          mode;
    fsq_state_e         state;
    logic       [15:0]  work_cnt;
    logic       [15:0]  work_cycles;
    logic               sequencer_ready_flag;
    logic               boot_s1;
    logic               boot_s2;
    logic               start_s1;
    logic               start_s2;
    logic               start_s3;
    fsq_word_t          monitor;
    fsq_word_t          next_rdata;
    logic               wr_freq;
    logic               wr_tmd;

    // A select on a macro literal is not legal, so the reset word gets a name first
    localparam fsq_word_t tmd_rst = `FSQ_TMD_RST;

    // Plain address compare, shared by every register decode
    function automatic logic hit(input logic [31:0] a, input logic [31:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo,
                                      input logic [31:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    // Pins from outside the clock domain
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            boot_s1  <= 1'b0;
            boot_s2  <= 1'b0;
            start_s1 <= 1'b0;
            start_s2 <= 1'b0;
            start_s3 <= 1'b0;
        end else begin
            boot_s1  <= SERIAL_BOOT;
            boot_s2  <= boot_s1;
            start_s1 <= CMD_START;
            start_s2 <= start_s1;
            start_s3 <= start_s2;
        end
    end

    assign sequencer_ready_flag = (state == FSQ_IDLE);
    assign wr_freq = WR && hit(ADDR, `FSQ_OFS_CLK_NOTIFY) && sequencer_ready_flag
                     && (WDATA[15:8] == `FSQ_KEY_FREQ);
    assign wr_tmd  = WR && hit(ADDR, `FSQ_OFS_ECC_TMD) && (WDATA[15:8] == `FSQ_KEY_ECC);

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            notified_freq_mhz <= `FSQ_FREQ_MAX;
        end else if (wr_freq) begin
            notified_freq_mhz <= WDATA[7:0];
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            tmd.code_verify_ecc_area_en <= tmd_rst[`FSQ_BIT_CVE];
            tmd.data_verify_ecc_area_en <= tmd_rst[`FSQ_BIT_DVE];
            tmd.encoder_disable         <= tmd_rst[`FSQ_BIT_EDIS];
        end else if (wr_tmd) begin
            tmd.code_verify_ecc_area_en <= WDATA[`FSQ_BIT_CVE];
            tmd.data_verify_ecc_area_en <= WDATA[`FSQ_BIT_DVE];
            tmd.encoder_disable         <= WDATA[`FSQ_BIT_EDIS];
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            dummy <= `FSQ_DUMMY_RST;
        end else if (WR && hit(ADDR, `FSQ_OFS_DUMMY)) begin
            dummy <= WDATA[9:0];
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            mode <= FSQ_READ;
        end else if (WR && hit(ADDR, `FSQ_OFS_MODE_ENTRY)) begin
            case (WDATA)
                `FSQ_MODE_CODE: mode <= FSQ_CODE;
                `FSQ_MODE_DATA: mode <= FSQ_DATA;
                `FSQ_MODE_READ: mode <= FSQ_READ;
                default:        mode <= mode;
            endcase
        end
    end

    // strap caught after release
    // The synchroniser is cleared by reset, so the strap is only valid at the third edge
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            firmware_map_sel <= 1'b0;
            boot_wait        <= 2'h0;
        end else if (boot_wait != 2'h3) begin
            boot_wait <= boot_wait + 2'h1;
            if (boot_wait == 2'h2) begin
                firmware_map_sel <= boot_s2;
            end
        end else if (WR && hit(ADDR, `FSQ_OFS_FW_SEL)) begin
            firmware_map_sel <= WDATA[0];
        end
    end

    assign work_cycles = 16'(notified_freq_mhz) * 16'(`FSQ_WORK_US);

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state    <= FSQ_IDLE;
            work_cnt <= 16'h0000;
        end else begin
            case (state)
                FSQ_IDLE: begin
                    if (start_s2 && !start_s3 && mode != FSQ_READ) begin
                        state    <= FSQ_RUN;
                        work_cnt <= work_cycles;
                    end
                end
                FSQ_RUN: begin
                    if (work_cnt <= 16'h0001) begin
                        state <= FSQ_IDLE;
                    end
                    work_cnt <= work_cnt - 16'h0001;
                end
                default: state <= FSQ_IDLE;
            endcase
        end
    end

    always_comb begin
        monitor = `FSQ_MON_RST;
        if (mode == FSQ_CODE) begin
            monitor = {`FSQ_MON_RSV, CODE_PARITY_IN, CODE_ECC_IN};
        end else if (mode == FSQ_DATA) begin
            monitor = {`FSQ_MON_RSV, 3'h7, DATA_ECC_IN};
        end
    end

    always_comb begin
        next_rdata = 16'h0000;
        if (hit(ADDR, `FSQ_OFS_CLK_NOTIFY)) begin
            next_rdata = {8'h00, notified_freq_mhz};
        end else if (hit(ADDR, `FSQ_OFS_ECC_MON)) begin
            next_rdata = monitor;
        end else if (hit(ADDR, `FSQ_OFS_ECC_TMD)) begin
            next_rdata = {10'h000, tmd.code_verify_ecc_area_en, tmd.data_verify_ecc_area_en,
                          3'h0, tmd.encoder_disable};
        end else if (hit(ADDR, `FSQ_OFS_DUMMY)) begin
            next_rdata = {`FSQ_MON_RSV, dummy};
        end else if (hit(ADDR, `FSQ_OFS_FW_SEL)) begin
            next_rdata = {15'h0000, firmware_map_sel};
        end else if (hit(ADDR, `FSQ_OFS_STATUS)) begin
            next_rdata = 16'(sequencer_ready_flag) << `FSQ_BIT_RDY;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            RDATA <= 16'h0000;
        end else begin
            RDATA <= RD ? next_rdata : 16'h0000;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            WRITE_CHECK     <= 10'h3FF;
            VERIFY_ECC_AREA <= 1'b0;
            READY           <= 1'b1;
        end else begin
            READY <= sequencer_ready_flag;
            if (mode == FSQ_DATA) begin
                WRITE_CHECK     <= {3'h7, tmd.encoder_disable ? dummy.ecc[6:0] : DATA_ECC_IN};
                VERIFY_ECC_AREA <= tmd.data_verify_ecc_area_en;
            end else begin
                WRITE_CHECK     <= tmd.encoder_disable ? dummy : {CODE_PARITY_IN, CODE_ECC_IN};
                VERIFY_ECC_AREA <= tmd.code_verify_ecc_area_en;
            end
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            FW_HIT     <= 1'b0;
            FW_ALT_HIT <= 1'b0;
        end else begin
            FW_HIT     <= firmware_map_sel && in_range(FETCH_ADDR, `FSQ_FW_LO, `FSQ_FW_HI);
            FW_ALT_HIT <= !firmware_map_sel
                          && in_range(FETCH_ADDR, `FSQ_FW_ALT_LO, `FSQ_FW_ALT_HI);
        end
    end

endmodule : fsq_regs

// ### sim/fsq_regs_asserts.sv
// Port checker for the sequencer register bank
`timescale 1ns/1ns
`include "fsq_regs_defs.svh"
module fsq_regs_asserts (
    input wire logic        CLK,
    input wire logic        ARST_N,
    input wire logic [31:0] ADDR,
    input wire logic        RD,
    input wire logic [15:0] RDATA,
    input wire logic        READY,
    input wire logic [31:0] FETCH_ADDR,
    input wire logic        FW_HIT,
    input wire logic        FW_ALT_HIT
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    sequence s_rd(logic [31:0] a);
        RD && ADDR == a;
    endsequence
    property p_key; s_rd(`FSQ_OFS_CLK_NOTIFY) |=> RDATA[15:8] == 8'h00; endproperty
    a_key: assert property (p_key) else $error("key byte read back");
    property p_tmd; s_rd(`FSQ_OFS_ECC_TMD) |=> {RDATA[15:6], RDATA[3:1]} == 13'h0000; endproperty
    a_tmd: assert property (p_tmd) else $error("test mode key or reserved");
    property p_mon; s_rd(`FSQ_OFS_ECC_MON) |=> RDATA[15:10] == `FSQ_MON_RSV; endproperty
    a_mon: assert property (p_mon) else $error("monitor reserved bits");
    property p_dmy; s_rd(`FSQ_OFS_DUMMY) |=> RDATA[15:10] == 6'h3F; endproperty
    a_dmy: assert property (p_dmy) else $error("dummy reserved bits");
    property p_fsel; s_rd(`FSQ_OFS_FW_SEL) |=> RDATA[15:1] == 15'h0000; endproperty
    a_fsel: assert property (p_fsel) else $error("select reserved bits");
    property p_fw; FW_HIT |-> $past(FETCH_ADDR) inside {[`FSQ_FW_LO:`FSQ_FW_HI]}; endproperty
    a_fw: assert property (p_fw) else $error("firmware hit out of window");
    property p_alt;
        FW_ALT_HIT |-> $past(FETCH_ADDR) inside {[`FSQ_FW_ALT_LO:`FSQ_FW_ALT_HI]};
    endproperty
    a_alt: assert property (p_alt) else $error("alternate hit out of window");
    // Any notified value of one or more keeps the sequencer busy for two cycles at least
    property p_busy; $fell(READY) |-> !READY [*2]; endproperty
    a_busy: assert property (p_busy) else $error("busy too short");
endmodule : fsq_regs_asserts
bind fsq_regs fsq_regs_asserts u_asserts (.CLK(CLK), .ARST_N(ARST_N), .ADDR(ADDR), .RD(RD),
    .RDATA(RDATA), .READY(READY), .FETCH_ADDR(FETCH_ADDR), .FW_HIT(FW_HIT),
    .FW_ALT_HIT(FW_ALT_HIT));

// ### sim/fsq_regs_bench.sv
// Directed bench for the sequencer register bank
`timescale 1ns/1ns
`include "fsq_regs_defs.svh"
module fsq_regs_bench;
    logic        CLK = 1'b0, ARST_N = 1'b0, WR = 1'b0, RD = 1'b0, CMD_START = 1'b0;
    logic        SERIAL_BOOT = 1'b1, CODE_PARITY_IN = 1'b1;
    logic [8:0]  CODE_ECC_IN = 9'h15A;
    logic [6:0]  DATA_ECC_IN = 7'h4B;
    logic [31:0] ADDR = 32'h0, FETCH_ADDR = 32'h0;
    logic [15:0] WDATA = 16'h0, RDATA;
    logic [9:0]  WRITE_CHECK;
    logic        READY, VERIFY_ECC_AREA, FW_HIT, FW_ALT_HIT;
    int          miscompares = 0, n_tests = 0, low_cnt = 0;
    always #4 CLK = ~CLK;
    always @(posedge CLK) low_cnt += int'(READY === 1'b0);
    fsq_regs dut (.CLK(CLK), .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .SERIAL_BOOT(SERIAL_BOOT), .CMD_START(CMD_START),
        .CODE_ECC_IN(CODE_ECC_IN), .CODE_PARITY_IN(CODE_PARITY_IN), .DATA_ECC_IN(DATA_ECC_IN),
        .FETCH_ADDR(FETCH_ADDR), .READY(READY), .WRITE_CHECK(WRITE_CHECK),
        .VERIFY_ECC_AREA(VERIFY_ECC_AREA), .FW_HIT(FW_HIT), .FW_ALT_HIT(FW_ALT_HIT));
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        ADDR  <= a;
        WDATA <= d;
        WR    <= 1'b1;
        @(posedge CLK);
        WR    <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [31:0] a, input logic [15:0] e);
        ADDR <= a;
        RD   <= 1'b1;
        @(posedge CLK);
        RD   <= 1'b0;
        #1 chk(RDATA, e);
        @(posedge CLK);
    endtask : rd
    task automatic fetch(input logic [31:0] a, input logic [15:0] e);
        FETCH_ADDR <= a;
        repeat (2) @(posedge CLK);
        chk(16'({FW_HIT, FW_ALT_HIT}), e);
    endtask : fetch
    task automatic do_reset;
        ARST_N <= 1'b0;
        repeat (3) @(posedge CLK);
        ARST_N <= 1'b1;
        repeat (2) @(posedge CLK);
    endtask : do_reset
    task automatic t_reset;
        rd(`FSQ_OFS_CLK_NOTIFY, 16'(`FSQ_FREQ_MAX));
        rd(`FSQ_OFS_ECC_TMD, `FSQ_TMD_RST);
        rd(`FSQ_OFS_DUMMY, 16'hFFFF);
        rd(`FSQ_OFS_ECC_MON, `FSQ_MON_RST);
        rd(`FSQ_OFS_FW_SEL, 16'(SERIAL_BOOT));
        rd(32'hFFA1010C, 16'h0000);
        $display("reset values done");
    endtask : t_reset
    task automatic t_key;
        wr(`FSQ_OFS_CLK_NOTIFY, 16'h5520);
        rd(`FSQ_OFS_CLK_NOTIFY, 16'(`FSQ_FREQ_MAX));
        wr(`FSQ_OFS_CLK_NOTIFY, 16'h1E20);
        rd(`FSQ_OFS_CLK_NOTIFY, 16'h0020);
        wr(`FSQ_OFS_ECC_TMD, 16'h0001);
        rd(`FSQ_OFS_ECC_TMD, `FSQ_TMD_RST);
        wr(`FSQ_OFS_ECC_TMD, 16'hA601);
        rd(`FSQ_OFS_ECC_TMD, 16'h0001);
        $display("key protection done");
    endtask : t_key
    task automatic t_busy;
        int n;
        wr(`FSQ_OFS_MODE_ENTRY, `FSQ_MODE_CODE);
        low_cnt = 0;
        CMD_START <= 1'b1;
        for (n = 0; n < 20 && READY !== 1'b0; n++)
            @(posedge CLK);
        // Refused while busy, so the later read still shows 20
        wr(`FSQ_OFS_CLK_NOTIFY, 16'h1E10);
        CMD_START <= 1'b0;
        for (n = 0; n < 200 && READY !== 1'b1; n++)
            @(posedge CLK);
        chk(16'(low_cnt), 16'(`FSQ_WORK_US) * 16'h0020);
        rd(`FSQ_OFS_CLK_NOTIFY, 16'h0020);
        $display("command timing done");
    endtask : t_busy
    task automatic t_ecc;
        wr(`FSQ_OFS_DUMMY, 16'hFEA5);
        rd(`FSQ_OFS_DUMMY, 16'hFEA5);
        chk(16'(WRITE_CHECK), 16'h02A5);
        wr(`FSQ_OFS_ECC_TMD, 16'hA630);
        rd(`FSQ_OFS_ECC_MON, {6'h3F, CODE_PARITY_IN, CODE_ECC_IN});
        chk(16'(WRITE_CHECK), {6'h00, CODE_PARITY_IN, CODE_ECC_IN});
        chk(16'(VERIFY_ECC_AREA), 16'h0001);
        wr(`FSQ_OFS_MODE_ENTRY, `FSQ_MODE_DATA);
        rd(`FSQ_OFS_ECC_MON, {9'h1FF, DATA_ECC_IN});
        wr(`FSQ_OFS_ECC_TMD, 16'hA621);
        rd(`FSQ_OFS_ECC_TMD, 16'h0021);
        chk(16'(WRITE_CHECK), 16'h03A5);
        chk(16'(VERIFY_ECC_AREA), 16'h0000);
        $display("ecc test done");
    endtask : t_ecc
    task automatic t_fw;
        fetch(`FSQ_FW_LO, 16'h0002);
        fetch(`FSQ_FW_HI + 32'h1, 16'h0000);
        fetch(`FSQ_FW_ALT_HI, 16'h0000);
        wr(`FSQ_OFS_FW_SEL, 16'h0000);
        fetch(`FSQ_FW_HI, 16'h0000);
        fetch(`FSQ_FW_ALT_LO, 16'h0001);
        fetch(`FSQ_FW_ALT_LO - 32'h1, 16'h0000);
        $display("firmware map done");
    endtask : t_fw
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : final_report
    initial begin
        @(posedge CLK);
        do_reset();
        t_reset();
        t_key();
        t_busy();
        t_ecc();
        t_fw();
        SERIAL_BOOT <= 1'b0;
        repeat (4) @(posedge CLK);
        do_reset();
        t_reset();
        final_report();
    end
    // The run needs well under a thousand cycles
    initial begin
        #100000;
        miscompares++;
        final_report();
    end
endmodule : fsq_regs_bench
